// *** logic/tmr3_pkg.sv ***
// Constants for the timer three control and capture block
package tmr3_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h91;
	localparam logic [7:0] ADDR_RLL  = 8'h92;
	localparam logic [7:0] ADDR_RLH  = 8'h93;
	localparam logic [7:0] ADDR_CNTL = 8'h94;
	localparam logic [7:0] ADDR_CNTH = 8'h95;
	localparam int BIT_HFLAG  = 7;
	localparam int BIT_LFLAG  = 6;
	localparam int BIT_LIRQEN = 5;
	localparam int BIT_CAPEN  = 4;
	localparam int BIT_SPLIT  = 3;
	localparam int BIT_RUN    = 2;
	localparam int BIT_XCLK   = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'hFD;
	localparam logic [7:0] BYTE_MAX   = 8'hFF;
	localparam logic [7:0] BYTE_ZERO  = 8'h00;
	localparam int SYS_DIV  = 12;
	localparam int EXT_DIV  = 8;
	localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
	localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);
endpackage

// *** logic/tmr3_control_capture.sv ***
// Timer three: 16-bit or split 8-bit auto-reload timer with capture mode

// What this block does
// - High flag sets on high byte roll from FF to its reload; only software clears it.
// - In 16-bit mode the high flag sets when the count wraps from FFFF and reloads.
// - With timer interrupt enabled, a set high flag requests the interrupt.
// - Low flag sets on every low byte roll, any mode; held until cleared.
// - Low overflows request interrupts only with low enable and timer enable.
// - Capture enable bit turns capture mode on and off.
// - Split bit 0 gives one 16-bit timer; 1 gives two 8-bit timers.
// - Run bit starts timer; in split mode it gates only the high byte.
// - Control bit 1 reads zero and ignores writes.
// - Clock select: 0 is system clock over 12, 1 external clock over 8.
// - In split mode external select serves both bytes unless overridden.
// - Wrap reloads 16-bit value; split bytes reload from their own bytes.
// - Capture: on each divided external falling edge copy count, set flag.
// - A byte clock select of 1 picks the undivided system clock.
module tmr3_control_capture (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [7:0] sfrAddr,
	input  wire logic       sfrWr,
	input  wire logic [7:0] sfrWdata,
	output logic      [7:0] sfrRdata,
	input  wire logic       highClkSel,
	input  wire logic       lowClkSel,
	input  wire logic       timerIrqEnable,
	input  wire logic       extClk,
	output logic            timerIrq
);
	logic [7:0] ctrl_q, ctrl_d;
	logic [7:0] cntL_q, cntL_d, cntH_q, cntH_d;
	logic [7:0] rlL_q, rlL_d, rlH_q, rlH_d;
	logic [3:0] sysDiv_q, sysDiv_d;
	logic [2:0] extDiv_q, extDiv_d;
	logic       extMeta_q, extSync_q, extPrev_q;
	logic       irq_q, irq_d;
	logic [7:0] rdata_q, rdata_d;
	logic       sysTick, extTick, loTick, hiTick, setH, setL;
	logic       split, run, capEn, xclk;

	assign split = ctrl_q[tmr3_pkg::BIT_SPLIT];
	assign run   = ctrl_q[tmr3_pkg::BIT_RUN];
	assign capEn = ctrl_q[tmr3_pkg::BIT_CAPEN];
	assign xclk  = ctrl_q[tmr3_pkg::BIT_XCLK];

	// Dividers for the two slow timer clocks
	always_comb begin
		sysTick  = (sysDiv_q == tmr3_pkg::SYS_DIV_LAST);
		sysDiv_d = sysTick ? 4'h0 : sysDiv_q + 4'h1;
		// External edge seen only after the second sync stage
		extDiv_d = extDiv_q;
		extTick  = 1'b0;
		if (extSync_q && !extPrev_q) begin
			extDiv_d = extDiv_q + 3'h1;
			// Divided clock falls as the count wraps
			extTick  = (extDiv_q == tmr3_pkg::EXT_DIV_LAST);
		end
		// Byte select of 1 overrides the external select
		loTick = lowClkSel  ? 1'b1 : (xclk ? extTick : sysTick);
		hiTick = highClkSel ? 1'b1 : (xclk ? extTick : sysTick);
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sysDiv_q  <= 4'h0;
			extDiv_q  <= 3'h0;
			extMeta_q <= 1'b0;
			extSync_q <= 1'b0;
			extPrev_q <= 1'b0;
		end else begin
			sysDiv_q  <= sysDiv_d;
			extDiv_q  <= extDiv_d;
			extMeta_q <= extClk;
			extSync_q <= extMeta_q;
			extPrev_q <= extSync_q;
		end
	end

	// Counting, reload, capture and register writes
	always_comb begin
		ctrl_d = ctrl_q;
		cntL_d = cntL_q;
		cntH_d = cntH_q;
		rlL_d  = rlL_q;
		rlH_d  = rlH_q;
		setH   = 1'b0;
		setL   = 1'b0;
		if (split) begin
			if (loTick) begin
				if (cntL_q == tmr3_pkg::BYTE_MAX) begin
					cntL_d = rlL_q;
					setL   = 1'b1;
				end else begin
					cntL_d = cntL_q + 8'h01;
				end
			end
			if (run && hiTick) begin
				if (cntH_q == tmr3_pkg::BYTE_MAX) begin
					cntH_d = rlH_q;
					setH   = 1'b1;
				end else begin
					cntH_d = cntH_q + 8'h01;
				end
			end
		end else if (run && loTick) begin
			if (cntL_q == tmr3_pkg::BYTE_MAX) begin
				setL = 1'b1;
				if (cntH_q == tmr3_pkg::BYTE_MAX) begin
					cntL_d = rlL_q;
					cntH_d = rlH_q;
					setH   = 1'b1;
				end else begin
					cntL_d = tmr3_pkg::BYTE_ZERO;
					cntH_d = cntH_q + 8'h01;
				end
			end else begin
				cntL_d = cntL_q + 8'h01;
			end
		end
		// Capture meant for 16-bit mode but not blocked in split mode
		if (capEn && extTick) begin
			rlL_d = cntL_q;
			rlH_d = cntH_q;
			setH  = 1'b1;
		end
		if (sfrWr) begin
			case (sfrAddr)
				tmr3_pkg::ADDR_CTRL: ctrl_d = sfrWdata & tmr3_pkg::CTRL_WMASK;
				tmr3_pkg::ADDR_RLL:  rlL_d  = sfrWdata;
				tmr3_pkg::ADDR_RLH:  rlH_d  = sfrWdata;
				tmr3_pkg::ADDR_CNTL: cntL_d = sfrWdata;
				tmr3_pkg::ADDR_CNTH: cntH_d = sfrWdata;
				default: ;
			endcase
		end
		// Hardware set wins over a same-cycle software clear
		if (setH) ctrl_d[tmr3_pkg::BIT_HFLAG] = 1'b1;
		if (setL) ctrl_d[tmr3_pkg::BIT_LFLAG] = 1'b1;
		irq_d = timerIrqEnable && (ctrl_q[tmr3_pkg::BIT_HFLAG] ||
			(ctrl_q[tmr3_pkg::BIT_LIRQEN] &&
			ctrl_q[tmr3_pkg::BIT_LFLAG]));
		case (sfrAddr)
			tmr3_pkg::ADDR_CTRL: rdata_d = ctrl_q & tmr3_pkg::CTRL_WMASK;
			tmr3_pkg::ADDR_RLL:  rdata_d = rlL_q;
			tmr3_pkg::ADDR_RLH:  rdata_d = rlH_q;
			tmr3_pkg::ADDR_CNTL: rdata_d = cntL_q;
			tmr3_pkg::ADDR_CNTH: rdata_d = cntH_q;
			default:             rdata_d = tmr3_pkg::BYTE_ZERO;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl_q  <= tmr3_pkg::CTRL_RESET;
			cntL_q  <= 8'h00;
			cntH_q  <= 8'h00;
			rlL_q   <= 8'h00;
			rlH_q   <= 8'h00;
			irq_q   <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			ctrl_q  <= ctrl_d;
			cntL_q  <= cntL_d;
			cntH_q  <= cntH_d;
			rlL_q   <= rlL_d;
			rlH_q   <= rlH_d;
			irq_q   <= irq_d;
			rdata_q <= rdata_d;
		end
	end

	assign sfrRdata = rdata_q;
	assign timerIrq = irq_q;

	logic wrCtrl, wrCnt, wrRl;
	assign wrCtrl = sfrWr && (sfrAddr == tmr3_pkg::ADDR_CTRL);
	assign wrCnt  = sfrWr && (sfrAddr == tmr3_pkg::ADDR_CNTL ||
		sfrAddr == tmr3_pkg::ADDR_CNTH);
	assign wrRl   = sfrWr && (sfrAddr == tmr3_pkg::ADDR_RLL ||
		sfrAddr == tmr3_pkg::ADDR_RLH);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	wrap_reload_a: assert property (!split && run && loTick && !wrCnt && !wrCtrl
		&& {cntH_q, cntL_q} == 16'hFFFF
		|=> ctrl_q[7] && ctrl_q[6] && {cntH_q, cntL_q} == $past({rlH_q, rlL_q}))
		else $error("16-bit wrap did not reload and flag");
	high_flag_hold_a: assert property (ctrl_q[7] && !wrCtrl |=> ctrl_q[7])
		else $error("high flag cleared without a write");
	low_flag_split_a: assert property (split && loTick && !wrCnt && !wrCtrl
		&& cntL_q == 8'hFF |=> ctrl_q[6] && cntL_q == $past(rlL_q))
		else $error("split low overflow not flagged");
	irq_high_a: assert property (timerIrqEnable && ctrl_q[7] |=> timerIrq)
		else $error("interrupt missing for high flag");
	irq_low_gate_a: assert property (!ctrl_q[7] && (!ctrl_q[5] ||
		!timerIrqEnable) |=> !timerIrq)
		else $error("low overflow interrupt not gated");
	bit_one_zero_a: assert property (wrCtrl |=> ctrl_q[1] == 1'b0)
		else $error("control bit 1 not zero");
	split_hold_a: assert property (split && !run && !wrCnt
		|=> cntH_q == $past(cntH_q))
		else $error("stopped high byte moved");
	capture_copy_a: assert property (capEn && extTick && !wrRl && !wrCtrl
		|=> rlH_q == $past(cntH_q) && rlL_q == $past(cntL_q) && ctrl_q[7])
		else $error("capture did not copy count");
	fast_clock_a: assert property (split && run && highClkSel && !wrCnt
		&& cntH_q != 8'hFF |=> cntH_q == $past(cntH_q) + 8'h01)
		else $error("high byte not on system clock");
	sys_div_a: assert property (sysTick |=> !sysTick [*8])
		else $error("system clock divider too fast");
	sys_period_a: assert property (sysTick |-> ##12 sysTick)
		else $error("system clock divider period wrong");
	low_flag_wide_a: assert property (!split && run && loTick && !wrCnt
		&& !wrCtrl && cntL_q == tmr3_pkg::BYTE_MAX
		|=> ctrl_q[tmr3_pkg::BIT_LFLAG])
		else $error("16-bit low overflow not flagged");

	wrap_c:    cover property (!split && run && setH);
	split_c:   cover property (split && setH ##[1:300] setL);
	capture_c: cover property (capEn && extTick);
	irq_c:     cover property (!timerIrq ##1 timerIrq);
endmodule

// *** tb/tmr3_control_capture_tb.sv ***
// Self-checking bench for the timer three control and capture block
module tmr3_control_capture_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rstn = 0, sfrWr = 0, extClk = 0;
	logic        highClkSel = 0, lowClkSel = 0, timerIrqEnable = 0;
	logic [7:0]  sfrAddr = 8'h00, sfrWdata = 8'h00;
	logic [7:0]  sfrRdata, v, h1, l1;
	logic        timerIrq;
	logic [15:0] c1;
	int          bad_count = 0, n_compared = 0, extCnt = 0, i;
	int          seed = 11832, extHalf = 4;

	tmr3_control_capture i_tmr3_control_capture (.clk(clk), .rstn(rstn),
		.sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrWdata(sfrWdata),
		.sfrRdata(sfrRdata), .highClkSel(highClkSel), .lowClkSel(lowClkSel),
		.timerIrqEnable(timerIrqEnable), .extClk(extClk), .timerIrq(timerIrq));

	initial begin
		forever #25 clk = ~clk;
	end

	// Edge-locked oscillator so capture spacing is exact in cycles
	always @(posedge clk) begin
		if (extCnt >= extHalf - 1) begin
			extCnt <= 0;
			extClk <= ~extClk;
		end else
			extCnt <= extCnt + 1;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfrAddr <= a;
		sfrWdata <= d;
		sfrWr <= 1'b1;
		@(posedge clk);
		sfrWr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		sfrAddr <= a;
		@(posedge clk);
		#1 d = sfrRdata;
	endtask

	task automatic waitFlag(input logic [7:0] m);
		for (i = 0; i < 300; i++) begin
			rd(tmr3_pkg::ADDR_CTRL, v);
			if ((v & m) === m)
				return;
		end
		bad_count++;
		$display("[ERR] %0t flag wait ran out", $time);
		end_sim();
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		extHalf = 4 + ($unsigned($random(seed)) % 8);
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		rd(8'h91, v);
		chk(v, tmr3_pkg::CTRL_RESET);
		rd(8'h96, v);
		chk(v, 16'h0000);
		wr(8'h91, 8'hFF);
		rd(8'h91, v);
		chk(v, 16'h00FD);
		wr(8'h91, 8'h00);
		done("register");
		@(posedge clk);
		lowClkSel <= 1'b1;
		timerIrqEnable <= 1'b1;
		h1 = 8'($random(seed));
		// Low reload kept small so the high byte holds still afterwards
		l1 = 8'($random(seed)) & 8'h7F;
		wr(8'h93, h1);
		wr(8'h92, l1);
		wr(8'h95, 8'hFF);
		wr(8'h94, 8'hF0);
		wr(8'h91, 8'h04);
		waitFlag(8'h80);
		chk(v & 8'hC0, 16'h00C0);
		wr(8'h91, 8'hC0);
		rd(8'h91, v);
		chk(v, 16'h00C0);
		chk(timerIrq, 1'b1);
		rd(8'h95, v);
		chk(v, h1);
		repeat (30) @(posedge clk);
		rd(8'h91, v);
		chk(v, 16'h00C0);
		wr(8'h91, 8'h00);
		rd(8'h91, v);
		chk(v, 16'h0000);
		chk(timerIrq, 1'b0);
		done("wrap");
		wr(8'h91, 8'h40);
		rd(8'h91, v);
		chk(timerIrq, 1'b0);
		wr(8'h91, 8'h60);
		rd(8'h91, v);
		chk(timerIrq, 1'b1);
		@(posedge clk);
		timerIrqEnable <= 1'b0;
		rd(8'h91, v);
		chk(timerIrq, 1'b0);
		wr(8'h91, 8'h00);
		done("low irq");
		@(posedge clk);
		highClkSel <= 1'b1;
		wr(8'h95, 8'h00);
		wr(8'h94, 8'hF0);
		wr(8'h91, 8'h08);
		waitFlag(8'h40);
		chk(v & 8'h80, 16'h0000);
		rd(8'h95, v);
		chk(v, 16'h0000);
		wr(8'h95, 8'hFE);
		wr(8'h91, 8'h0C);
		waitFlag(8'h80);
		wr(8'h91, 8'h00);
		done("split");
		@(posedge clk);
		highClkSel <= 1'b0;
		lowClkSel <= 1'b0;
		wr(8'h94, 8'h00);
		wr(8'h91, 8'h04);
		repeat (120) @(posedge clk);
		wr(8'h91, 8'h00);
		rd(8'h94, v);
		chk(16'(v >= 8'h09 && v <= 8'h0B), 16'h0001);
		done("prescale");
		wr(8'h95, 8'h00);
		wr(8'h94, 8'h00);
		wr(8'h91, 8'h0D);
		// Window of three whole divided periods gives an exact count
		repeat (48 * extHalf - 2) @(posedge clk);
		wr(8'h91, 8'h00);
		rd(8'h94, v);
		chk(v, 16'h0003);
		rd(8'h95, v);
		chk(v, 16'h0003);
		done("external");
		@(posedge clk);
		lowClkSel <= 1'b1;
		// Count starts low so no wrap spoils the capture spacing
		wr(8'h95, 8'h00);
		wr(8'h94, 8'h00);
		wr(8'h91, 8'h14);
		waitFlag(8'h80);
		wr(8'h91, 8'h14);
		waitFlag(8'h80);
		rd(8'h93, h1);
		rd(8'h92, l1);
		c1 = {h1, l1};
		wr(8'h91, 8'h14);
		waitFlag(8'h80);
		rd(8'h93, h1);
		rd(8'h92, l1);
		chk({h1, l1} - c1, 16'(16 * extHalf));
		wr(8'h94, 8'h00);
		wr(8'h91, 8'h04);
		repeat (200) @(posedge clk);
		rd(8'h91, v);
		chk(v, 16'h0004);
		rd(8'h92, v);
		chk(v, l1);
		done("capture");
		end_sim();
	end
endmodule
